// ### hw/bcdra_pkg.sv
// Package with constants and types for the BCD root and binary add datapath.
// What this block does
// RULE1: With execution condition low, no result word or flag changes.
// RULE2: Square root takes eight BCD digits from two words, writes BCD root.
// RULE3: The root is truncated to its integer part, never rounded.
// RULE4: Fault flag rises on non-BCD radicand or bad indirect data memory reference.
// RULE5: Zero flag is set when the written result equals zero.
// RULE6: Binary add sums both operand words plus the carry flag into the result.
// RULE7: Binary add sets carry when the full sum exceeds ffff.
// RULE8: Carry lives in a fixed special relay status bit readable after the add.
// RULE9: Set-carry and clear-carry operations force the carry flag.
// RULE10: Binary add treats operands as unsigned hexadecimal, not BCD.
// RULE11: Sources from any area; results only to io, aux, data, holding, link.
// RULE12: Binary add clears carry otherwise and writes only the low 16 bits.
// RULE13: Higher source word gives the four high radicand digits, lower the low.
`default_nettype none
package bcdra_pkg;
   localparam int          WORD_W        = 16;
   localparam int          ADDR_W        = 4;
   localparam logic [3:0]  ADR_CMD       = 4'h0;
   localparam logic [3:0]  ADR_OPA       = 4'h1;
   localparam logic [3:0]  ADR_OPB       = 4'h2;
   localparam logic [3:0]  ADR_RAD_LO    = 4'h3;
   localparam logic [3:0]  ADR_RAD_HI    = 4'h4;
   localparam logic [3:0]  ADR_IND       = 4'h5;
   localparam logic [3:0]  ADR_RESULT    = 4'h6;
   localparam logic [3:0]  ADR_FLAGS     = 4'h7;
   localparam logic [3:0]  ADR_INT_STAT  = 4'h8;
   localparam logic [3:0]  ADR_INT_MASK  = 4'h9;
   localparam int          CMD_OP_LSB    = 0;
   localparam int          CMD_EXEC_BIT  = 3;
   localparam int          CMD_DST_LSB   = 4;
   localparam int          CMD_IND_BIT   = 7;
   localparam int          FLG_BUSY_BIT  = 0;
   localparam int          FLG_FAULT_BIT = 3;
   localparam int          FLG_CARRY_BIT = 4;
   localparam int          FLG_ZERO_BIT  = 6;
   localparam int          INT_W         = 3;
   localparam int          INT_DONE_BIT  = 0;
   localparam int          INT_FAULT_BIT = 1;
   localparam int          INT_CARRY_BIT = 2;
   localparam logic [15:0] RST_WORD      = 16'h0000;
   localparam logic [2:0]  RST_INT       = 3'h0;
   // Top of the indirectly addressable data memory; set it to suit the memory fitted.
   localparam logic [15:0] DM_LAST       = 16'h3999;
   localparam logic [16:0] ADD_MAX       = 17'h0ffff;
   localparam int          ROOT_CONV_CYC = 8;
   localparam int          ROOT_ITER_CYC = 14;
   localparam int          ROOT_DABB_CYC = 14;
   localparam int          ROOT_LAT      = ROOT_CONV_CYC + ROOT_ITER_CYC + ROOT_DABB_CYC + 1;

   typedef enum logic [2:0] {
      OP_NOP  = 3'h0,
      OP_ADD  = 3'h1,
      OP_ROOT = 3'h2,
      OP_SETC = 3'h3,
      OP_CLRC = 3'h4
   } bcdra_op_e;

   typedef enum logic [2:0] {
      AREA_IO      = 3'h0,
      AREA_SPECIAL = 3'h1,
      AREA_AUX     = 3'h2,
      AREA_DATA    = 3'h3,
      AREA_HOLD    = 3'h4,
      AREA_TIMER   = 3'h5,
      AREA_LINK    = 3'h6,
      AREA_CONST   = 3'h7
   } bcdra_area_e;
endpackage
`default_nettype wire

// ### hw/bcdra_root_if.sv
// Interface between the datapath control and the square root engine.
`timescale 1ns/1ps
`default_nettype none
interface bcdra_root_if;
   logic        start;
   logic [31:0] radicand;
   logic        done;
   logic [15:0] root_bcd;
   modport ctrl (output start, output radicand, input done, input root_bcd);
   modport eng (input start, input radicand, output done, output root_bcd);
endinterface
`default_nettype wire

// ### hw/bcdra_root.sv
// Sequential BCD square root engine: BCD to binary, bit-pair root, double dabble.
`timescale 1ns/1ps
`default_nettype none
module bcdra_root
   import bcdra_pkg::*;
(
   input wire logic     clk_i,
   input wire logic     rst_n_i,
   input wire logic     ce_i,
   bcdra_root_if.eng    rif
);
   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CONV = 3'b001,
      ST_ITER = 3'b011,
      ST_DABB = 3'b010,
      ST_DONE = 3'b110
   } bcdra_st_e;

   bcdra_st_e   state_r;
   logic [31:0] digits_r;
   logic [27:0] bin_r;
   logic [17:0] rem_r;
   logic [13:0] root_r;
   logic [13:0] root_bin_r;
   logic [15:0] bcd_r;
   logic [3:0]  cnt_r;
   logic [17:0] rem_sh;
   logic [17:0] trial;
   logic [15:0] adj;

   // Bit pairs of the binary radicand are taken from the top, one per step.
   assign rem_sh = {rem_r[15:0], 2'(bin_r >> (5'h1a - {cnt_r, 1'b0}))};
   assign trial  = {2'b00, root_r, 2'b01};

   genvar g;
   generate
      for (g = 0; g < 4; g++) begin : g_dig
         assign adj[4*g +: 4] = (bcd_r[4*g +: 4] >= 4'h5) ? bcd_r[4*g +: 4] + 4'h3
                                                          : bcd_r[4*g +: 4];
      end
   endgenerate

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r <= ST_IDLE;
         cnt_r   <= 4'h0;
      end else if (ce_i) begin
         case (state_r)
            ST_IDLE: if (rif.start) begin
               state_r <= ST_CONV;
               cnt_r   <= 4'h0;
            end
            ST_CONV: begin
               cnt_r <= (cnt_r == 4'(ROOT_CONV_CYC - 1)) ? 4'h0 : cnt_r + 4'h1;
               if (cnt_r == 4'(ROOT_CONV_CYC - 1)) state_r <= ST_ITER;
            end
            ST_ITER: begin
               cnt_r <= (cnt_r == 4'(ROOT_ITER_CYC - 1)) ? 4'h0 : cnt_r + 4'h1;
               if (cnt_r == 4'(ROOT_ITER_CYC - 1)) state_r <= ST_DABB;
            end
            ST_DABB: begin
               cnt_r <= cnt_r + 4'h1;
               if (cnt_r == 4'(ROOT_DABB_CYC - 1)) state_r <= ST_DONE;
            end
            ST_DONE: state_r <= ST_IDLE;
            default: state_r <= ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         digits_r   <= 32'h0;
         bin_r      <= 28'h0;
         rem_r      <= 18'h0;
         root_r     <= 14'h0;
         root_bin_r <= 14'h0;
         bcd_r      <= RST_WORD;
      end else if (ce_i) begin
         if (state_r == ST_IDLE && rif.start) begin
            digits_r <= rif.radicand;
            bin_r    <= 28'h0;
            rem_r    <= 18'h0;
            root_r   <= 14'h0;
            bcd_r    <= RST_WORD;
         end else if (state_r == ST_CONV) begin
            // Most significant digit first, so the high source word leads. (see RULE13)
            bin_r    <= 28'(bin_r * 28'ha) + 28'(digits_r[31:28]);
            digits_r <= {digits_r[27:0], 4'h0};
         end else if (state_r == ST_ITER) begin
            // Remainder is dropped, which truncates the root. (see RULE3)
            if (rem_sh >= trial) begin
               rem_r  <= rem_sh - trial;
               root_r <= {root_r[12:0], 1'b1};
            end else begin
               rem_r  <= rem_sh;
               root_r <= {root_r[12:0], 1'b0};
            end
         end else if (state_r == ST_DABB) begin
            if (cnt_r == 4'h0) root_bin_r <= root_r;
            bcd_r  <= {adj[14:0], root_r[13]};
            root_r <= {root_r[12:0], 1'b0};
         end
      end
   end

   assign rif.done     = (state_r == ST_DONE);
   assign rif.root_bcd = bcd_r;

   root_trunc_a: assert property (@(posedge clk_i) disable iff (!rst_n_i) // see RULE3
      (state_r == ST_DONE) |-> (29'(root_bin_r) * 29'(root_bin_r) <= 29'(bin_r)) &&
         ((29'(root_bin_r) + 29'h1) * (29'(root_bin_r) + 29'h1) > 29'(bin_r)))
      else $error("root not truncated integer root");
endmodule // bcdra_root
`default_nettype wire

// ### hw/bcdra_top.sv
// Top of the BCD square root and binary add datapath with its register port.
//
// Our own choices: the address-and-strobe port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module bcdra_top
   import bcdra_pkg::*;
(
   input  wire logic              MCLK_I,
   input  wire logic              RESETN_I,
   input  wire logic              CE_I,
   input  wire logic [ADDR_W-1:0] ADDR_I,
   input  wire logic [WORD_W-1:0] WDATA_I,
   input  wire logic              WR_I,
   input  wire logic              RD_I,
   output logic      [WORD_W-1:0] RDATA_O,
   output logic                   IRQ_O,
   output logic                   CARRY_FLAG_O,
   output logic                   FAULT_FLAG_O,
   output logic                   ZERO_FLAG_O
);
   bcdra_root_if rif ();

   logic [15:0]      cmd_r;
   logic [15:0]      opa_r;
   logic [15:0]      opb_r;
   logic [15:0]      rad_lo_r;
   logic [15:0]      rad_hi_r;
   logic [15:0]      ind_ptr_r;
   logic [15:0]      result_r;
   logic             carry_r;
   logic             fault_r;
   logic             zero_r;
   logic             busy_r;
   logic [INT_W-1:0] int_stat_r;
   logic [INT_W-1:0] int_stat_nxt;
   logic [INT_W-1:0] int_mask_r;
   logic [INT_W-1:0] int_ev;
   logic [15:0]      rdata_r;
   logic [15:0]      rdata_nxt;
   logic [15:0]      flags_word;

   logic             wr;
   logic             rd;
   logic             cmd_wr;
   logic             exec;
   logic             go;
   logic             arith;
   logic             ind_bad;
   logic             dst_bad;
   logic             rad_bad;
   logic             fault_now;
   logic             add_go;
   logic             root_go;
   logic             root_done;
   logic             setc_go;
   logic             clrc_go;
   logic [16:0]      sum;
   bcdra_op_e        op;
   bcdra_area_e      dst;

   function automatic logic is_bcd(input logic [15:0] w);
      logic ok;
      ok = 1'b1;
      for (int i = 0; i < 4; i++) begin
         if (w[4*i +: 4] > 4'h9) ok = 1'b0;
      end
      return ok;
   endfunction

   // Command decode. The clock enable gates every strobe, so a frozen block
   // ignores the port as well as holding its state.
   assign wr     = WR_I && CE_I;
   assign rd     = RD_I && CE_I;
   assign cmd_wr = wr && (ADDR_I == ADR_CMD);
   assign exec   = WDATA_I[CMD_EXEC_BIT];
   assign op     = bcdra_op_e'(WDATA_I[CMD_OP_LSB +: 3]);
   assign dst    = bcdra_area_e'(WDATA_I[CMD_DST_LSB +: 3]);
   // A command is refused while a root is running; nothing is queued.
   assign go     = cmd_wr && exec && !busy_r; // see RULE1
   assign arith  = (op == OP_ADD) || (op == OP_ROOT);

   // An indirect operand must point at a BCD address inside the data memory.
   assign ind_bad = WDATA_I[CMD_IND_BIT] &&
                    (!is_bcd(ind_ptr_r) || (ind_ptr_r > DM_LAST)); // see RULE4
   // Sources may come from any area; results only to writable word areas.
   assign dst_bad = !((dst == AREA_IO) || (dst == AREA_AUX) || (dst == AREA_DATA) ||
                      (dst == AREA_HOLD) || (dst == AREA_LINK)); // see RULE11
   assign rad_bad = !is_bcd(rad_hi_r) || !is_bcd(rad_lo_r); // see RULE4

   assign fault_now = go && arith && (ind_bad || dst_bad || ((op == OP_ROOT) && rad_bad));
   assign add_go    = go && (op == OP_ADD) && !fault_now;
   assign root_go   = go && (op == OP_ROOT) && !fault_now;
   assign setc_go   = go && (op == OP_SETC);
   assign clrc_go   = go && (op == OP_CLRC);
   assign root_done = rif.done && CE_I;

   // Unsigned seventeen bit sum including the incoming carry. (see RULE6) (see RULE10)
   assign sum = {1'b0, opa_r} + {1'b0, opb_r} + {16'h0000, carry_r};

   // Radicand digits: high word first. (see RULE13)
   assign rif.start    = root_go; // see RULE2
   assign rif.radicand = {rad_hi_r, rad_lo_r};

   bcdra_root u_root (
      .clk_i   (MCLK_I),
      .rst_n_i (RESETN_I),
      .ce_i    (CE_I),
      .rif     (rif.eng)
   );

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         cmd_r     <= RST_WORD;
         opa_r     <= RST_WORD;
         opb_r     <= RST_WORD;
         rad_lo_r  <= RST_WORD;
         rad_hi_r  <= RST_WORD;
         ind_ptr_r <= RST_WORD;
      end else if (wr) begin
         case (ADDR_I)
            ADR_CMD:    cmd_r     <= WDATA_I;
            ADR_OPA:    opa_r     <= WDATA_I;
            ADR_OPB:    opb_r     <= WDATA_I;
            ADR_RAD_LO: rad_lo_r  <= WDATA_I;
            ADR_RAD_HI: rad_hi_r  <= WDATA_I;
            ADR_IND:    ind_ptr_r <= WDATA_I;
            default:    cmd_r     <= cmd_r;
         endcase
      end
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         int_mask_r <= RST_INT;
      end else if (wr && (ADDR_I == ADR_INT_MASK)) begin
         int_mask_r <= WDATA_I[INT_W-1:0];
      end
   end

   // Result word: only low sixteen bits of the sum; faults write nothing.
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         result_r <= RST_WORD;
      end else if (CE_I) begin
         if (add_go) begin
            result_r <= sum[15:0]; // see RULE12
         end else if (root_done) begin
            result_r <= rif.root_bcd; // see RULE2
         end
      end
   end

   // Carry is touched only by add, set-carry and clear-carry.
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         carry_r <= 1'b0;
      end else if (CE_I) begin
         if (add_go) begin
            carry_r <= (sum > ADD_MAX); // see RULE7
         end else if (setc_go) begin
            carry_r <= 1'b1; // see RULE9
         end else if (clrc_go) begin
            carry_r <= 1'b0; // see RULE9
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         zero_r <= 1'b0;
      end else if (CE_I) begin
         if (add_go) begin
            zero_r <= (sum[15:0] == 16'h0000); // see RULE5
         end else if (root_done) begin
            zero_r <= (rif.root_bcd == 16'h0000); // see RULE5
         end
      end
   end

   // Each executed arithmetic operation leaves the fault flag at its own verdict.
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         fault_r <= 1'b0;
      end else if (CE_I) begin
         if (fault_now) begin
            fault_r <= 1'b1; // see RULE4
         end else if (add_go || root_done) begin
            fault_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         busy_r <= 1'b0;
      end else if (CE_I) begin
         if (root_go) begin
            busy_r <= 1'b1;
         end else if (root_done) begin
            busy_r <= 1'b0;
         end
      end
   end

   // Interrupt status: sticky, cleared by writing one, a new event wins.
   always_comb begin
      int_ev                = '0;
      int_ev[INT_DONE_BIT]  = add_go || root_done || fault_now || setc_go || clrc_go;
      int_ev[INT_FAULT_BIT] = fault_now;
      int_ev[INT_CARRY_BIT] = add_go && sum[16];
      int_stat_nxt          = int_stat_r;
      if (wr && (ADDR_I == ADR_INT_STAT)) int_stat_nxt = int_stat_nxt & ~WDATA_I[INT_W-1:0];
      int_stat_nxt          = int_stat_nxt | int_ev;
   end

   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         int_stat_r <= RST_INT;
      end else if (CE_I) begin
         int_stat_r <= int_stat_nxt;
      end
   end

   // Carry sits at a fixed bit of the status word. (see RULE8)
   always_comb begin
      flags_word                = '0;
      flags_word[FLG_BUSY_BIT]  = busy_r;
      flags_word[FLG_FAULT_BIT] = fault_r;
      flags_word[FLG_CARRY_BIT] = carry_r;
      flags_word[FLG_ZERO_BIT]  = zero_r;
   end

   always_comb begin
      rdata_nxt = 16'h0000;
      if (rd) begin
         case (ADDR_I)
            ADR_CMD:      rdata_nxt = cmd_r;
            ADR_OPA:      rdata_nxt = opa_r;
            ADR_OPB:      rdata_nxt = opb_r;
            ADR_RAD_LO:   rdata_nxt = rad_lo_r;
            ADR_RAD_HI:   rdata_nxt = rad_hi_r;
            ADR_IND:      rdata_nxt = ind_ptr_r;
            ADR_RESULT:   rdata_nxt = result_r;
            ADR_FLAGS:    rdata_nxt = flags_word;
            ADR_INT_STAT: rdata_nxt = {13'h0000, int_stat_r};
            ADR_INT_MASK: rdata_nxt = {13'h0000, int_mask_r};
            default:      rdata_nxt = 16'h0000;
         endcase
      end
   end

   // Read data stand for exactly one cycle; zero otherwise keeps the bus quiet.
   always_ff @(posedge MCLK_I or negedge RESETN_I) begin
      if (!RESETN_I) begin
         rdata_r <= RST_WORD;
      end else if (CE_I) begin
         rdata_r <= rdata_nxt;
      end
   end

   assign RDATA_O      = rdata_r;
   assign IRQ_O        = |(int_stat_r & int_mask_r);
   assign CARRY_FLAG_O = carry_r;
   assign FAULT_FLAG_O = fault_r;
   assign ZERO_FLAG_O  = zero_r;

   sequence root_run_s;
      busy_r ##36 (busy_r && rif.done);
   endsequence

   cond_off_hold_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE1
      (cmd_wr && !exec && !root_done) |=> $stable(result_r) && $stable(carry_r) &&
         $stable(fault_r) && $stable(zero_r))
      else $error("state changed with execution condition low");

   root_run_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I || !CE_I) // see RULE2
      root_go |=> root_run_s ##1 (!busy_r && !fault_r))
      else $error("root did not complete in time");

   fault_ind_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE4
      (go && arith && (ind_bad || ((op == OP_ROOT) && rad_bad))) |=> fault_r && $stable(result_r))
      else $error("bad operand did not raise fault");

   zero_flag_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE5
      (add_go || root_done) |=> (zero_r == (result_r == 16'h0000)))
      else $error("zero flag disagrees with result");

   add_sum_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE6
      add_go |=> (result_r == 16'($past(opa_r) + $past(opb_r) + 16'($past(carry_r)))))
      else $error("add result wrong");

   add_carry_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE7
      add_go |=> (carry_r == (({1'b0, $past(opa_r)} + {1'b0, $past(opb_r)} +
         {16'h0000, $past(carry_r)}) > ADD_MAX)))
      else $error("add carry wrong");

   carry_bit_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE8
      (rd && (ADDR_I == ADR_FLAGS)) |=> (RDATA_O[FLG_CARRY_BIT] == $past(carry_r)))
      else $error("carry not at its status bit");

   carry_force_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE9
      (setc_go |=> carry_r) and (clrc_go |=> !carry_r))
      else $error("carry force failed");

   dest_area_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE11
      (go && arith && dst_bad) |=> fault_r && $stable(result_r) && !busy_r)
      else $error("write to forbidden area");

   // The checks below look one edge after the event, where the registers have settled.
   // Frozen cycles must leave every architectural register alone, so a stalled
   // controller resumes exactly where it stopped.
   ce_freeze_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE1
      !CE_I |=> $stable(result_r) && $stable(carry_r) && $stable(fault_r) &&
         $stable(zero_r) && $stable(int_stat_r))
      else $error("state changed while clock enable was low");

   root_write_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE2
      root_done |=> !busy_r && (result_r == $past(rif.root_bcd)))
      else $error("root result not written on completion");

   root_refuse_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE4
      (go && (op == OP_ROOT) && fault_now) |=> !busy_r && $stable(zero_r) && $stable(result_r))
      else $error("faulted root started or wrote");

   fault_event_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE4
      fault_now |=> fault_r && int_stat_r[INT_FAULT_BIT])
      else $error("fault event not latched");

   carry_event_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE7
      (add_go && (sum > ADD_MAX)) |=> carry_r && int_stat_r[INT_CARRY_BIT])
      else $error("carry event not latched");

   // Carry must survive anything but add and the two force operations, since
   // software reads it after the add to chain a higher-order word.
   carry_keep_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE8
      !(add_go || setc_go || clrc_go) |=> $stable(carry_r))
      else $error("carry changed outside add or force");

   add_clear_a: assert property (@(posedge MCLK_I) disable iff (!RESETN_I) // see RULE12
      (add_go && (({1'b0, opa_r} + {1'b0, opb_r} + {16'h0000, carry_r}) <= ADD_MAX))
         |=> !carry_r)
      else $error("carry not cleared by add without overflow");
endmodule // bcdra_top
`default_nettype wire

// ### sim/bcd_root_binary_add_tb.sv
// Self-checking testbench for the BCD root and binary add datapath.
`timescale 1ns/1ps
`default_nettype none
module bcd_root_binary_add_tb;
   import bcdra_pkg::*;
   logic              clk;
   logic              rst_n;
   logic              ce;
   logic [ADDR_W-1:0] addr;
   logic [WORD_W-1:0] wdata;
   logic              wr;
   logic              rd;
   logic [WORD_W-1:0] rdata;
   logic              irq;
   logic              carry;
   logic              fault;
   logic              zero;
   int                failures;
   int                cmp_count;
   logic [15:0]       d;
   // Columns: high radicand word, low radicand word, expected root, expected fault.
   logic [15:0]       rt [0:4][0:3] = '{'{16'h0000, 16'h6017, 16'h0077, 16'h0},
                                       '{16'h0001, 16'h0000, 16'h0100, 16'h0},
                                       '{16'h9999, 16'h9999, 16'h9999, 16'h0},
                                       '{16'h0000, 16'h0000, 16'h0000, 16'h0},
                                       '{16'h0000, 16'h00a1, 16'h0000, 16'h1}};

   bcdra_top dut (
      .MCLK_I       (clk),
      .RESETN_I     (rst_n),
      .CE_I         (ce),
      .ADDR_I       (addr),
      .WDATA_I      (wdata),
      .WR_I         (wr),
      .RD_I         (rd),
      .RDATA_O      (rdata),
      .IRQ_O        (irq),
      .CARRY_FLAG_O (carry),
      .FAULT_FLAG_O (fault),
      .ZERO_FLAG_O  (zero)
   );

   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   task automatic end_of_test;
      $display("comparisons %0d failures %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr_reg(input logic [3:0] a, input logic [15:0] v);
      @(posedge clk);
      addr  <= a;
      wdata <= v;
      wr    <= 1'b1;
      @(posedge clk);
      wr    <= 1'b0;
   endtask

   // Read data stand only in the cycle after the strobe, so sample just past that edge.
   task automatic rd_reg(input logic [3:0] a, output logic [15:0] v);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 v = rdata;
   endtask

   function automatic logic [15:0] cmd(input logic [2:0] op, input logic ex,
                                       input logic [2:0] dst, input logic ind);
      return {8'h00, ind, dst, ex, op};
   endfunction

   function automatic logic [15:0] fl(input logic f, input logic c, input logic z);
      return {9'h000, z, 1'b0, c, f, 3'h0};
   endfunction

   // Issues an executed command, waits on busy, then checks result and flags.
   task automatic run(input logic [2:0] op, input logic [2:0] dst, input logic ind,
                      input logic [15:0] er, input logic f, input logic c, input logic z);
      int n;
      n = 0;
      wr_reg(ADR_CMD, cmd(op, 1'b1, dst, ind));
      do begin
         rd_reg(ADR_FLAGS, d);
         n++;
      end while (d[FLG_BUSY_BIT] !== 1'b0 && n < 60);
      rd_reg(ADR_RESULT, d);
      chk(d, er);
      rd_reg(ADR_FLAGS, d);
      chk(d, fl(f, c, z));
      chk({13'h0, carry, fault, zero}, {13'h0, c, f, z});
   endtask

   initial begin
      #(20000 * 25);
      failures++;
      end_of_test();
   end

   initial begin
      rst_n     = 1'b0;
      ce        = 1'b1;
      addr      = '0;
      wdata     = '0;
      wr        = 1'b0;
      rd        = 1'b0;
      failures  = 0;
      cmp_count = 0;
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      // Every register clears on reset and unmapped addresses read as zero.
      for (int a = 0; a < 16; a++) begin
         rd_reg(a[3:0], d);
         chk(d, 16'h0000);
      end
      run(OP_CLRC, AREA_IO, 1'b0, 16'h0000, 1'b0, 1'b0, 1'b0);
      wr_reg(ADR_OPA, 16'ha6e2);
      wr_reg(ADR_OPB, 16'h80c5);
      run(OP_ADD, AREA_DATA, 1'b0, 16'h27a7, 1'b0, 1'b1, 1'b0);
      wr_reg(ADR_OPA, 16'h4f52);
      wr_reg(ADR_OPB, 16'hec3b);
      run(OP_ADD, AREA_HOLD, 1'b0, 16'h3b8e, 1'b0, 1'b1, 1'b0);
      wr_reg(ADR_OPA, 16'h0001);
      wr_reg(ADR_OPB, 16'h0002);
      run(OP_ADD, AREA_LINK, 1'b0, 16'h0004, 1'b0, 1'b0, 1'b0);
      run(OP_SETC, AREA_IO, 1'b0, 16'h0004, 1'b0, 1'b1, 1'b0);
      wr_reg(ADR_OPA, 16'hfffe);
      wr_reg(ADR_OPB, 16'h0000);
      run(OP_ADD, AREA_AUX, 1'b0, 16'hffff, 1'b0, 1'b0, 1'b0);
      run(OP_SETC, AREA_IO, 1'b0, 16'hffff, 1'b0, 1'b1, 1'b0);
      wr_reg(ADR_OPB, 16'h0001);
      run(OP_ADD, AREA_AUX, 1'b0, 16'h0000, 1'b0, 1'b1, 1'b1);
      wr_reg(ADR_OPA, 16'h1234);
      wr_reg(ADR_OPB, 16'h0000);
      wr_reg(ADR_CMD, cmd(OP_ADD, 1'b0, AREA_DATA, 1'b0));
      rd_reg(ADR_RESULT, d);
      chk(d, 16'h0000);
      rd_reg(ADR_FLAGS, d);
      chk(d, fl(1'b0, 1'b1, 1'b1));
      // A strobe with the clock enable low must not start anything.
      @(posedge clk);
      ce <= 1'b0;
      wr_reg(ADR_CMD, cmd(OP_ADD, 1'b1, AREA_DATA, 1'b0));
      ce <= 1'b1;
      rd_reg(ADR_RESULT, d);
      chk(d, 16'h0000);
      run(OP_ADD, AREA_IO, 1'b0, 16'h1235, 1'b0, 1'b0, 1'b0);
      wr_reg(ADR_INT_STAT, 16'h0007);
      wr_reg(ADR_INT_MASK, 16'h0002);
      // The mask lands on the edge that ends the write, so look once it has settled.
      @(negedge clk);
      chk({15'h0, irq}, 16'h0000);
      run(OP_ADD, AREA_SPECIAL, 1'b0, 16'h1235, 1'b1, 1'b0, 1'b0);
      run(OP_ADD, AREA_TIMER, 1'b0, 16'h1235, 1'b1, 1'b0, 1'b0);
      run(OP_ADD, AREA_CONST, 1'b0, 16'h1235, 1'b1, 1'b0, 1'b0);
      chk({15'h0, irq}, 16'h0001);
      rd_reg(ADR_INT_STAT, d);
      chk(d, 16'h0003);
      wr_reg(ADR_INT_STAT, 16'h0002);
      rd_reg(ADR_INT_STAT, d);
      chk(d, 16'h0001);
      chk({15'h0, irq}, 16'h0000);
      wr_reg(ADR_IND, 16'h4000);
      run(OP_ADD, AREA_DATA, 1'b1, 16'h1235, 1'b1, 1'b0, 1'b0);
      wr_reg(ADR_IND, 16'h00a0);
      run(OP_ADD, AREA_DATA, 1'b1, 16'h1235, 1'b1, 1'b0, 1'b0);
      wr_reg(ADR_IND, 16'h3999);
      run(OP_ADD, AREA_DATA, 1'b1, 16'h1234, 1'b0, 1'b0, 1'b0);
      // Root leaves carry alone; a faulted root keeps the previous result and zero flag.
      for (int i = 0; i < 5; i++) begin
         wr_reg(ADR_RAD_HI, rt[i][0]);
         wr_reg(ADR_RAD_LO, rt[i][1]);
         run(OP_ROOT, AREA_DATA, 1'b0, rt[i][2], rt[i][3][0], 1'b0, i > 2);
      end
      end_of_test();
   end
endmodule // bcd_root_binary_add_tb
`default_nettype wire
